// ### hdl/cmd_engine_defines.svh
`ifndef CMD_ENGINE_DEFINES_SVH
`define CMD_ENGINE_DEFINES_SVH

// -----------------------------------------
// Register byte offsets
// -----------------------------------------
`define OFF_FLAG 8'h00
`define OFF_MASK 8'h04
`define OFF_STAT0 8'h08
`define OFF_STAT1 8'h0C
`define OFF_CAPAB 8'h10
`define OFF_CMD0 8'h14
`define OFF_CMD1 8'h18
`define OFF_REPLY0 8'h1C
`define OFF_REPLY1 8'h20

// -----------------------------------------
// Field positions and widths
// -----------------------------------------
`define FLAG_LSB 6
`define CAP_LSB 5
`define CMD_W 16
`define TMR_W 16

// -----------------------------------------
// Capability field codes
// -----------------------------------------
`define CAP_BG1 3'b011
`define CAP_BG2 3'b101
`define CAP_FG1 3'b010
`define CAP_FG2 3'b100

// -----------------------------------------
// Status result codes and commands
// -----------------------------------------
`define CODE_RUN 6'h00
`define CODE_OK 6'h01
`define CODE_ABORT 6'h02
`define CODE_TMO 6'h03
`define CMD_ABORT 16'h0004

// -----------------------------------------
// Timing
// -----------------------------------------
`define CAPTURE_CYC 3'h4
`define EXEC_TIMEOUT_US 1000
`define CLK_MHZ 50

`endif

// ### hdl/cmd_engine_pkg.sv
`include "cmd_engine_defines.svh"

package cmd_engine_pkg;

   // -----------------------------------------
   // Executor answer, one per instance
   // -----------------------------------------
   typedef struct packed {
      logic done;
      logic ok;
      logic [5:0] code;
      logic [`CMD_W-1:0] reply;
   } exec_rsp_t;

   // -----------------------------------------
   // Per-instance state
   // -----------------------------------------
   typedef struct packed {
      logic busy;
      logic pend;
      logic [2:0] cap;
      logic [`TMR_W-1:0] tmr;
      logic [6:0] stat;
      logic [`CMD_W-1:0] cmdId;
      logic [`CMD_W-1:0] reply;
      logic start;
      logic abort;
   } inst_t;

   // -----------------------------------------
   // Whole engine state
   // -----------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic [7:0] addr;
      logic rdy;
      logic [31:0] rdata;
      inst_t [1:0] inst;
      logic [1:0] flag;
      logic [1:0] mask;
      logic irq;
   } engine_t;

endpackage : cmd_engine_pkg

// ### hdl/cmd_message_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_engine_defines.svh"

module cmd_message_engine
   import cmd_engine_pkg::*;
#(
   parameter bit BACKGROUND = 1'b1,
   parameter int NUM_INST = 2,
   parameter logic [2:0] CAPTURE_CYC = `CAPTURE_CYC,
   parameter int EXEC_TIMEOUT_CYC = `EXEC_TIMEOUT_US * `CLK_MHZ
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Command executor, bit or field i per instance
   output logic [1:0] execStart,
   output logic [1:0] execAbort,
   output logic [2*`CMD_W-1:0] execCmdId,
   input wire exec_rsp_t [1:0] execRsp,
   // Completion interrupt
   output logic intReq
);

   // -----------------------------------------
   // Constants
   // -----------------------------------------
   localparam logic [`TMR_W-1:0] TmoLoad = `TMR_W'(EXEC_TIMEOUT_CYC);
   localparam int CapBound = 12;

   // Capability field, fixed by build options
   localparam logic [2:0] CapField = BACKGROUND ?
      ((NUM_INST == 2) ? `CAP_BG2 : `CAP_BG1) :
      ((NUM_INST == 2) ? `CAP_FG2 : `CAP_FG1);

   // -----------------------------------------
   // Reset release
   // -----------------------------------------
   logic [1:0] rstPipe_q;
   logic rstn;

   // Async assert, two-stage release
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe_q <= 2'b00;
      end else begin
         rstPipe_q <= {rstPipe_q[0], 1'b1};
      end
   end

   assign rstn = rstPipe_q[1];

   // -----------------------------------------
   // State and working signals
   // -----------------------------------------
   engine_t s_q;
   engine_t s_d;
   logic accept;
   logic commit;
   logic wrEn;
   logic hold;
   logic [1:0] trig;
   logic [1:0] flagSet;
   logic [1:0] w1c;
   logic [7:0] rsel;
   logic [31:0] rd;
   logic anyBusy;

   assign anyBusy = s_q.inst[0].busy || s_q.inst[1].busy;

   // -----------------------------------------
   // Next-state logic
   // -----------------------------------------
   always_comb begin
      s_d = s_q;
      flagSet = 2'b00;
      w1c = 2'b00;
      trig = 2'b00;
      rd = 32'h0000_0000;

      // Bus phase tracking
      accept = hsel && hready && htrans[1];
      commit = s_q.valid && s_q.rdy;
      wrEn = commit && s_q.write && s_q.word;

      // Command word write is the trigger
      if (wrEn && (s_q.addr == `OFF_CMD0)) begin
         trig[0] = 1'b1;
      end
      // Bank one is dead with a single instance
      if (wrEn && (s_q.addr == `OFF_CMD1) && (NUM_INST == 2)) begin
         trig[1] = 1'b1;
      end

      // Shared executor for both instances
      for (int i = 0; i < 2; i++) begin
         s_d.inst[i].start = 1'b0;
         s_d.inst[i].abort = 1'b0;
         if (s_q.inst[i].pend) begin
            // Status landed last cycle, now raise the flag
            s_d.inst[i].pend = 1'b0;
            s_d.inst[i].busy = 1'b0;
            flagSet[i] = 1'b1;
         end else if (trig[i] && s_q.inst[i].busy) begin
            // Only abort gets through while busy
            if (hwdata[`CMD_W-1:0] == `CMD_ABORT) begin
               s_d.inst[i].abort = 1'b1;
               s_d.inst[i].stat = {1'b1, `CODE_ABORT};
               s_d.inst[i].pend = 1'b1;
            end
         end else if (trig[i]) begin
            // Capture; header kept for the reply
            s_d.inst[i].busy = 1'b1;
            s_d.inst[i].cap = CAPTURE_CYC;
            s_d.inst[i].stat = {1'b0, `CODE_RUN};
            s_d.inst[i].cmdId = hwdata[`CMD_W-1:0];
         end else if (s_q.inst[i].busy && (s_q.inst[i].cap != 3'h0)) begin
            // Capture window, start the executor at its end
            s_d.inst[i].cap = s_q.inst[i].cap - 3'h1;
            if (s_q.inst[i].cap == 3'h1) begin
               s_d.inst[i].start = 1'b1;
               s_d.inst[i].tmr = TmoLoad;
            end
         end else if (s_q.inst[i].busy && execRsp[i].done) begin
            // Judge result, keep reply body, write code
            s_d.inst[i].stat[6] = !execRsp[i].ok;
            s_d.inst[i].stat[5:0] = execRsp[i].ok ? `CODE_OK : execRsp[i].code;
            s_d.inst[i].reply = execRsp[i].reply;
            s_d.inst[i].pend = 1'b1;
         end else if (s_q.inst[i].busy && (s_q.inst[i].tmr <= `TMR_W'(1))) begin
            // Stuck executor still ends in a reply
            s_d.inst[i].abort = 1'b1;
            s_d.inst[i].stat = {1'b1, `CODE_TMO};
            s_d.inst[i].pend = 1'b1;
         end else if (s_q.inst[i].busy) begin
            s_d.inst[i].tmr = s_q.inst[i].tmr - `TMR_W'(1);
         end
      end

      // Flags: write one to clear, a set in the same cycle wins
      if (wrEn && (s_q.addr == `OFF_FLAG)) begin
         w1c = s_q.write ? hwdata[`FLAG_LSB +: 2] : 2'b00;
      end
      s_d.flag = (s_q.flag & ~w1c) | flagSet;
      if (wrEn && (s_q.addr == `OFF_MASK)) begin
         s_d.mask = hwdata[`FLAG_LSB +: 2];
      end
      // Masked flag gate onto one line
      s_d.irq = |(s_d.flag & ~s_d.mask);

      // Access hold-off: whole command in foreground, capture in background
      if (!BACKGROUND) begin
         hold = s_d.inst[0].busy || s_d.inst[1].busy;
      end else begin
         hold = (s_d.inst[0].cap != 3'h0) || (s_d.inst[1].cap != 3'h0);
      end

      // Data phase bookkeeping
      if (accept) begin
         s_d.valid = 1'b1;
         s_d.write = hwrite;
         s_d.word = (hsize == 3'b010);
         s_d.addr = haddr[7:0];
      end else if (commit) begin
         s_d.valid = 1'b0;
      end
      // Wait states only inside a data phase
      s_d.rdy = !((accept || (s_q.valid && !s_q.rdy)) && hold);

      // Read mux shows post-edge state, so a read sees its own cycle
      rsel = accept ? haddr[7:0] : s_q.addr;
      case (rsel)
         `OFF_FLAG: rd[`FLAG_LSB +: 2] = s_d.flag;
         `OFF_MASK: rd[`FLAG_LSB +: 2] = s_d.mask;
         `OFF_STAT0: rd[7:0] = {s_d.inst[0].busy, s_d.inst[0].stat};
         `OFF_STAT1: rd[7:0] = {s_d.inst[1].busy, s_d.inst[1].stat};
         `OFF_CAPAB: rd[`CAP_LSB +: 3] = CapField;
         `OFF_CMD0: rd[`CMD_W-1:0] = s_d.inst[0].cmdId;
         `OFF_CMD1: rd[`CMD_W-1:0] = s_d.inst[1].cmdId;
         `OFF_REPLY0: rd[`CMD_W-1:0] = s_d.inst[0].reply;
         `OFF_REPLY1: rd[`CMD_W-1:0] = s_d.inst[1].reply;
         default: rd = 32'h0000_0000;
      endcase
      if (accept || (s_q.valid && !s_q.rdy)) begin
         s_d.rdata = rd;
      end
   end

   // -----------------------------------------
   // State register
   // -----------------------------------------
   // Idle bus sees ready high from the first cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.rdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------
   // Outputs straight from the state register, hresp tied low
   // -----------------------------------------
   assign hreadyout = s_q.rdy;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign execStart = {s_q.inst[1].start, s_q.inst[0].start};
   assign execAbort = {s_q.inst[1].abort, s_q.inst[0].abort};
   assign execCmdId = {s_q.inst[1].cmdId, s_q.inst[0].cmdId};
   assign intReq = s_q.irq;

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // Completion steps of instance zero
   sequence s_done0;
      s_q.inst[0].pend ##1 (s_q.flag[0] && !s_q.inst[0].busy);
   endsequence

   property p_stat_then_flag;
      $rose(s_q.inst[0].pend) |-> s_done0;
   endproperty
   a_stat_then_flag: assert property (p_stat_then_flag)
      else $error("done flag not one cycle after status");

   property p_flag_irq;
      ($rose(s_q.flag[0]) && !s_q.mask[0]) |-> s_q.irq;
   endproperty
   a_flag_irq: assert property (p_flag_irq)
      else $error("unmasked done flag gave no interrupt");

   property p_mask_quiet;
      (s_q.mask == 2'b11) |-> !s_q.irq;
   endproperty
   a_mask_quiet: assert property (p_mask_quiet)
      else $error("interrupt with all flags masked");

   property p_fg_stall;
      (!BACKGROUND && s_q.valid && anyBusy && $past(anyBusy)) |-> !s_q.rdy;
   endproperty
   a_fg_stall: assert property (p_fg_stall)
      else $error("foreground access served while busy");

   property p_fg_status_stall;
      (!BACKGROUND && s_q.valid && !s_q.write && anyBusy &&
       (s_q.addr == `OFF_STAT0 || s_q.addr == `OFF_STAT1)) |-> !s_q.rdy;
   endproperty
   a_fg_status_stall: assert property (p_fg_status_stall)
      else $error("foreground status read served while busy");

   property p_fg_resume;
      (!BACKGROUND && $fell(anyBusy)) |-> (s_q.flag != 2'b00 || !$past(s_q.rdy)) && s_q.rdy;
   endproperty
   a_fg_resume: assert property (p_fg_resume)
      else $error("foreground access not resumed with flag");

   property p_bg_capture;
      (BACKGROUND && $rose(s_q.inst[0].busy)) |-> ##[1:CapBound] s_q.rdy;
   endproperty
   a_bg_capture: assert property (p_bg_capture)
      else $error("background hold-off outlasted capture");

   property p_single_bank;
      (NUM_INST == 1) |-> !s_q.inst[1].busy;
   endproperty
   a_single_bank: assert property (p_single_bank)
      else $error("bank one active with one instance");

   property p_ignore_busy;
      (trig[0] && s_q.inst[0].busy && !s_q.inst[0].pend &&
       hwdata[`CMD_W-1:0] != `CMD_ABORT) |=> $stable(s_q.inst[0].cmdId) && !s_q.inst[0].pend;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("command to busy instance not ignored");

   property p_abort;
      (trig[0] && s_q.inst[0].busy && !s_q.inst[0].pend &&
       hwdata[`CMD_W-1:0] == `CMD_ABORT) |=> s_q.inst[0].abort ##0 s_done0;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort did not end busy command");

   property p_start_after_capture;
      s_q.inst[0].start |-> s_q.inst[0].busy && s_q.inst[0].cap == 3'h0 &&
         $past(s_q.inst[0].cap) == 3'h1;
   endproperty
   a_start_after_capture: assert property (p_start_after_capture)
      else $error("executor started outside capture end");

   property p_timeout;
      (s_q.inst[0].busy && !s_q.inst[0].pend && s_q.inst[0].cap == 3'h0 &&
       s_q.inst[0].tmr == `TMR_W'(1) && !trig[0]) |=> s_q.inst[0].pend;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("expired command produced no reply");

   // Completion steps of instance one
   sequence s_done1;
      s_q.inst[1].pend ##1 (s_q.flag[1] && !s_q.inst[1].busy);
   endsequence

   property p_stat_then_flag1;
      $rose(s_q.inst[1].pend) |-> s_done1;
   endproperty
   a_stat_then_flag1: assert property (p_stat_then_flag1)
      else $error("bank one flag not one cycle after status");

   property p_flag_irq1;
      ($rose(s_q.flag[1]) && !s_q.mask[1]) |-> s_q.irq;
   endproperty
   a_flag_irq1: assert property (p_flag_irq1)
      else $error("unmasked bank one flag gave no interrupt");

   property p_start_after_capture1;
      s_q.inst[1].start |-> s_q.inst[1].busy && s_q.inst[1].cap == 3'h0 &&
         $past(s_q.inst[1].cap) == 3'h1;
   endproperty
   a_start_after_capture1: assert property (p_start_after_capture1)
      else $error("bank one executor started outside capture end");

   // A clear written in the completing cycle must not eat the flag
   property p_set_wins;
      flagSet[0] |=> s_q.flag[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("done flag lost to a same-cycle clear");

   property p_header_kept;
      s_q.inst[0].busy |=> $stable(s_q.inst[0].cmdId);
   endproperty
   a_header_kept: assert property (p_header_kept)
      else $error("command header changed while busy");

   // Bit five of the code tells software which processing style it gets
   property p_cap_read;
      (s_q.valid && s_q.rdy && !s_q.write && s_q.addr == `OFF_CAPAB) |->
         s_q.rdata[`CAP_LSB] == BACKGROUND;
   endproperty
   a_cap_read: assert property (p_cap_read)
      else $error("capability bit five wrong for processing style");

endmodule : cmd_message_engine
`default_nettype wire

// ### verif/exec_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_engine_defines.svh"

// ------------------------------------------
// Command executor behind both instances
// ------------------------------------------
module exec_model
   import cmd_engine_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Engine side
   input wire logic [1:0] execStart,
   input wire logic [1:0] execAbort,
   input wire logic [2*`CMD_W-1:0] execCmdId,
   output var exec_rsp_t [1:0] execRsp,
   // Bench control: delay per instance, pass or fail
   input wire logic [15:0] rspDelay,
   input wire logic [1:0] rspOk
);
   logic [7:0] cnt_q [2];
   logic [1:0] run_q;

   // Answer after the set delay; idle fields toggle so stale values never pass
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         run_q <= 2'b00;
         execRsp <= '0;
         cnt_q <= '{8'h00, 8'h00};
      end else begin
         for (int i = 0; i < 2; i++) begin
            execRsp[i] <= {1'b0, ~execRsp[i][22:0]};
            if (execStart[i]) begin
               run_q[i] <= 1'b1;
               cnt_q[i] <= rspDelay[8*i+:8];
            end else if (execAbort[i]) begin
               run_q[i] <= 1'b0;
            end else if (run_q[i] && cnt_q[i] == 8'h00) begin
               run_q[i] <= 1'b0;
               execRsp[i] <= {1'b1, rspOk[i], 6'h2A, ~execCmdId[16*i+:16]};
            end else if (run_q[i]) begin
               cnt_q[i] <= cnt_q[i] - 8'h01;
            end
         end
      end
   end
endmodule : exec_model
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_engine_defines.svh"

module testbench
   import cmd_engine_pkg::*;
;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, intReq;
   logic [31:0] hrdata, d;
   logic [1:0] execStart, execAbort;
   logic [2*`CMD_W-1:0] execCmdId;
   exec_rsp_t [1:0] execRsp;
   logic [15:0] rspDelay = 16'h0A0A;
   logic [1:0] rspOk = 2'b11;
   int fail_count = 0;
   int cmp_count = 0;
   int w;
   // Second build on the same bus, picked by fg between transfers
   logic fg = 1'b0;
   logic hselFg = 1'b0;
   logic readyFg, hrespFg, intReqFg, busRdy;
   logic [31:0] rdataFg, busRdata;
   logic [1:0] startFg, abortFg;
   logic [2*`CMD_W-1:0] cmdIdFg;
   exec_rsp_t [1:0] rspFg;

   assign busRdy = fg ? readyFg : hreadyout;
   assign busRdata = fg ? rdataFg : hrdata;

   always #10 core_clk = ~core_clk;

   cmd_message_engine #(.EXEC_TIMEOUT_CYC(40)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .execStart(execStart), .execAbort(execAbort), .execCmdId(execCmdId),
      .execRsp(execRsp), .intReq(intReq));

   exec_model i_exec (
      .core_clk(core_clk), .resetn(resetn), .execStart(execStart),
      .execAbort(execAbort), .execCmdId(execCmdId), .execRsp(execRsp),
      .rspDelay(rspDelay), .rspOk(rspOk));

   // Foreground single-instance build
   cmd_message_engine #(.BACKGROUND(1'b0), .NUM_INST(1), .EXEC_TIMEOUT_CYC(40)) i_dutFg (
      .core_clk(core_clk), .resetn(resetn), .hsel(hselFg), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(readyFg), .hreadyout(readyFg), .hresp(hrespFg), .hrdata(rdataFg),
      .execStart(startFg), .execAbort(abortFg), .execCmdId(cmdIdFg),
      .execRsp(rspFg), .intReq(intReqFg));

   exec_model i_execFg (
      .core_clk(core_clk), .resetn(resetn), .execStart(startFg),
      .execAbort(abortFg), .execCmdId(cmdIdFg), .execRsp(rspFg),
      .rspDelay(rspDelay), .rspOk(rspOk));

   // ------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------
   // One single transfer at a time, never overlapped
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output int wt);
      hsel <= !fg;
      hselFg <= fg;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do begin
         @(posedge core_clk);
      end while (busRdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      wt = -1;
      // Wait-state cycles are simply waited out; only the watchdog ends a wait
      do begin
         @(posedge core_clk);
         wt++;
      end while (busRdy !== 1'b1);
      rd = busRdata;
   endtask : xfer

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      int t;
      xfer(a, 1'b0, 32'h0, v, t);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      int t;
      xfer(a, 1'b1, v, x, t);
   endtask : wr

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check

   // Poll a status register until its busy bit drops
   task automatic wait_done(input logic [7:0] a);
      logic [31:0] v;
      int n;
      n = 0;
      do begin
         rd(a, v);
         n++;
      end while (v[7] !== 1'b0 && n < 300);
      check(v & 32'h80, 32'h0);
   endtask : wait_done

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------
   // Tests
   // ------------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      // Reset values, capability code, unmapped place
      rd(`OFF_FLAG, d); check(d, 32'h0);
      rd(`OFF_MASK, d); check(d, 32'h0);
      rd(`OFF_CAPAB, d); check(d, 32'hA0);
      rd(8'h40, d); check(d, 32'h0);
      // Foreground build: whole command stalls the bus, bank one is dead
      fg = 1'b1;
      rd(`OFF_CAPAB, d); check(d, 32'h40);
      wr(`OFF_CMD1, 32'h0033);
      rd(`OFF_STAT1, d); check(d, 32'h0);
      wr(`OFF_CMD0, 32'h0042);
      xfer(`OFF_STAT0, 1'b0, 32'h0, d, w);
      check(d, 32'h01);
      check((w > 10) ? 32'h1 : 32'h0, 32'h1);
      check({31'h0, hrespFg}, 32'h0);
      rd(`OFF_FLAG, d); check(d, 32'h40);
      check({31'h0, intReqFg}, 32'h1);
      rd(`OFF_REPLY0, d); check(d, 32'hFFBD);
      wr(`OFF_FLAG, 32'h40);
      fg = 1'b0;
      // Bank zero success; read right behind the trigger only waits for capture
      wr(`OFF_CMD0, 32'h1234);
      xfer(`OFF_STAT0, 1'b0, 32'h0, d, w);
      check(d, 32'h80);
      check((w > 5) ? 32'h1 : 32'h0, 32'h0);
      check({31'h0, hresp}, 32'h0);
      check({16'h0, execCmdId[15:0]}, 32'h1234);
      wait_done(`OFF_STAT0);
      rd(`OFF_STAT0, d); check(d, 32'h01);
      rd(`OFF_FLAG, d); check(d, 32'h40);
      check({31'h0, intReq}, 32'h1);
      rd(`OFF_REPLY0, d); check(d, 32'hEDCB);
      rd(`OFF_CMD0, d); check(d, 32'h1234);
      // Mask holds the request back, flag clears by writing one
      wr(`OFF_MASK, 32'h40);
      rd(`OFF_MASK, d); check(d, 32'h40);
      check({31'h0, intReq}, 32'h0);
      wr(`OFF_FLAG, 32'h40);
      rd(`OFF_FLAG, d); check(d, 32'h0);
      wr(`OFF_MASK, 32'h0);
      // Both banks at once; bank one fails first while bank zero runs
      rspDelay <= {8'd3, 8'd35};
      rspOk <= 2'b01;
      wr(`OFF_CMD0, 32'h0101);
      wr(`OFF_CMD1, 32'h0055);
      wait_done(`OFF_STAT1);
      rd(`OFF_STAT0, d); check(d & 32'h80, 32'h80);
      rd(`OFF_STAT1, d); check(d, 32'h6A);
      rd(`OFF_FLAG, d); check(d, 32'h80);
      rd(`OFF_REPLY1, d); check(d, 32'hFFAA);
      // New command to a busy bank is dropped, abort ends it
      wr(`OFF_CMD0, 32'h7777);
      rd(`OFF_CMD0, d); check(d, 32'h0101);
      wr(`OFF_CMD0, 32'h0004);
      wait_done(`OFF_STAT0);
      rd(`OFF_STAT0, d); check(d & 32'hBF, 32'h02);
      wr(`OFF_FLAG, 32'hC0);
      // Silent executor still gets a reply by timeout
      rspDelay <= {8'd3, 8'd200};
      wr(`OFF_CMD0, 32'h0200);
      wait_done(`OFF_STAT0);
      rd(`OFF_STAT0, d); check(d, 32'h43);
      rd(`OFF_FLAG, d); check(d & 32'h40, 32'h40);
      // Hung command recovered by a mid-run reset
      wr(`OFF_CMD0, 32'h0300);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(`OFF_STAT0, d); check(d, 32'h0);
      rd(`OFF_FLAG, d); check(d, 32'h0);
      check({31'h0, intReq}, 32'h0);
      tally_and_finish();
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
